// *** src/typec_source_cc_attach_control.sv ***
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cc_attach_params.svh"
module typec_source_cc_attach_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic current_adv_select,
  input wire logic cc1_rd_det,
  input wire logic cc1_ra_det,
  input wire logic cc2_rd_det,
  input wire logic cc2_ra_det,
  input wire logic overcurrent,
  input wire logic overtemp_device,
  input wire logic overtemp_switch,
  output cc_attach_pkg::port_drive_t drive,
  output logic sink_attached_n_flag_o,
  output logic sink_attached_n_flag_oe_n,
  output logic flip_orientation_n_flag_o,
  output logic flip_orientation_n_flag_oe_n,
  output logic fault_n_flag_o,
  output logic fault_n_flag_oe_n
);
  localparam logic [`DEB_W-1:0] DEB_MAX = `DEB_W'(`DEBOUNCE_CYC - 1);

  // Two-flop synchronisers for all pin inputs
  // Each pin gets its own flop; combining before the first stage would glitch
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end else begin
      sync1_r <= {enable_pin, current_adv_select, cc1_rd_det, cc1_ra_det,
                  cc2_rd_det, cc2_ra_det, overcurrent, overtemp_device, overtemp_switch};
      sync2_r <= sync1_r;
    end
  end
  logic en_s, sel_s, fault_s;
  cc_attach_pkg::cc_pair_t cc_now;
  assign en_s = sync2_r[8];
  assign sel_s = sync2_r[7];
  assign fault_s = |sync2_r[2:0];
  assign cc_now.cc1 = sync2_r[6] ? cc_attach_pkg::TERM_RD :
                      (sync2_r[5] ? cc_attach_pkg::TERM_RA : cc_attach_pkg::TERM_OPEN);
  assign cc_now.cc2 = sync2_r[4] ? cc_attach_pkg::TERM_RD :
                      (sync2_r[3] ? cc_attach_pkg::TERM_RA : cc_attach_pkg::TERM_OPEN);

  // Software enable; the port runs only when pin and bit are both high
  logic [31:0] ctrl_r;
  logic port_en;
  assign port_en = en_s & ctrl_r[`CTRL_ENABLE_BIT];

  // Debounce: a CC pattern must hold steady before it is acted on
  cc_attach_pkg::cc_pair_t cc_last_r, cc_stable_r;
  logic [`DEB_W-1:0] deb_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_last_r <= '0;
      cc_stable_r <= '0;
      deb_cnt_r <= '0;
    end else begin
      cc_last_r <= cc_now;
      if (cc_now != cc_last_r) begin
        deb_cnt_r <= '0;
      end else if (deb_cnt_r == DEB_MAX) begin
        cc_stable_r <= cc_now;
      end else begin
        deb_cnt_r <= deb_cnt_r + 1'b1;
      end
    end
  end

  logic rd1_st, rd2_st, rd_now_any;
  assign rd1_st = (cc_stable_r.cc1 == cc_attach_pkg::TERM_RD);
  assign rd2_st = (cc_stable_r.cc2 == cc_attach_pkg::TERM_RD);
  // Prompt detach uses the raw synchronised view, not the debounced one
  assign rd_now_any = (cc_now.cc1 == cc_attach_pkg::TERM_RD) |
                      (cc_now.cc2 == cc_attach_pkg::TERM_RD);

  cc_attach_pkg::attach_state_t state_r, state_nxt;
  logic flipped_r;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cc_attach_pkg::ST_UNATTACHED: begin
        // Ra alone or another source never leaves this state
        if (port_en && rd_now_any) begin
          state_nxt = cc_attach_pkg::ST_WAIT_ATTACH;
        end
      end
      cc_attach_pkg::ST_WAIT_ATTACH: begin
        if (!port_en || !rd_now_any) begin
          state_nxt = cc_attach_pkg::ST_UNATTACHED;
        // Debounced view may be stale after a quick replug; it must match live
        end else if ((cc_stable_r == cc_now) && (rd1_st || rd2_st)) begin
          state_nxt = cc_attach_pkg::ST_ATTACHED;
        end
      end
      cc_attach_pkg::ST_ATTACHED: begin
        if (!port_en || !rd_now_any) begin
          state_nxt = cc_attach_pkg::ST_UNATTACHED;
        end
      end
      default: state_nxt = cc_attach_pkg::ST_UNATTACHED;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cc_attach_pkg::ST_UNATTACHED;
    end else begin
      state_r <= state_nxt;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flipped_r <= 1'b0;
    end else if (state_r == cc_attach_pkg::ST_WAIT_ATTACH &&
                 state_nxt == cc_attach_pkg::ST_ATTACHED) begin
      flipped_r <= !rd1_st && rd2_st;
    end
  end

  logic att_nxt, fault_act;
  assign att_nxt = (state_nxt == cc_attach_pkg::ST_ATTACHED);
  assign fault_act = fault_s & port_en;

  // Port drive, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      // Fault cuts power and VCONN; recovers by itself
      drive.power_on <= att_nxt && !fault_act;
      drive.vconn_cc1 <= att_nxt && !fault_act && rd2_st &&
                         cc_stable_r.cc1 == cc_attach_pkg::TERM_RA;
      drive.vconn_cc2 <= att_nxt && !fault_act && rd1_st &&
                         cc_stable_r.cc2 == cc_attach_pkg::TERM_RA;
      // Strap is passed through even while unattached
      drive.adv_15a <= sel_s;
    end
  end

  // Open-drain flags: data stays low, only the enable moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_attached_n_flag_o <= 1'b0;
      sink_attached_n_flag_oe_n <= 1'b1;
    end else begin
      sink_attached_n_flag_o <= 1'b0;
      sink_attached_n_flag_oe_n <= !att_nxt;
    end
  end

  // Orientation is latched at attach so a later Ra change cannot flip it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip_orientation_n_flag_o <= 1'b0;
      flip_orientation_n_flag_oe_n <= 1'b1;
    end else begin
      flip_orientation_n_flag_o <= 1'b0;
      flip_orientation_n_flag_oe_n <= !(att_nxt &&
        ((state_r == cc_attach_pkg::ST_ATTACHED) ? flipped_r : (!rd1_st && rd2_st)));
    end
  end

  // Fault flag hidden while disabled; clears itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_n_flag_o <= 1'b0;
      fault_n_flag_oe_n <= 1'b1;
    end else begin
      fault_n_flag_o <= 1'b0;
      fault_n_flag_oe_n <= !fault_act;
    end
  end

  // Cycles that some Rd has been seen without a break, for the debounce check
  logic [`DEB_W-1:0] rd_age_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_age_r <= '0;
    end else if (!rd_now_any) begin
      rd_age_r <= '0;
    end else if (rd_age_r != '1) begin
      rd_age_r <= rd_age_r + 1'b1;
    end
  end

  // APB slave, zero wait states
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_ATTACHED_BIT] = !sink_attached_n_flag_oe_n;
    status[`ST_FLIPPED_BIT] = !flip_orientation_n_flag_oe_n;
    status[`ST_POWER_BIT] = drive.power_on;
    status[`ST_VCONN1_BIT] = drive.vconn_cc1;
    status[`ST_VCONN2_BIT] = drive.vconn_cc2;
    status[`ST_FAULT_BIT] = !fault_n_flag_oe_n;
    status[`ST_ADV15_BIT] = drive.adv_15a;
    status[`ST_ENABLED_BIT] = port_en;
  end
  logic acc;
  assign acc = psel & penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET_VAL;
    end else if (acc && pwrite && paddr == `REG_CTRL_ADDR) begin
      ctrl_r <= {31'h0, pwdata[`CTRL_ENABLE_BIT]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & !penable;
      pslverr <= psel & !penable & (paddr != `REG_CTRL_ADDR) & (paddr != `REG_STATUS_ADDR);
      if (psel && !penable && !pwrite) begin
        prdata <= (paddr == `REG_CTRL_ADDR) ? ctrl_r :
                  ((paddr == `REG_STATUS_ADDR) ? status : 32'h0000_0000);
      end
    end
  end

  AST_NO_RD_NO_POWER: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_now_any |=> !drive.power_on) else $error("power on without Rd");
  AST_RA_ONLY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_now_any |=> sink_attached_n_flag_oe_n && !drive.vconn_cc1 && !drive.vconn_cc2)
    else $error("activity without sink");
  AST_DISABLED_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !port_en |=> !drive.power_on && sink_attached_n_flag_oe_n)
    else $error("active while disabled");
  AST_POWER_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    drive.power_on |-> !sink_attached_n_flag_oe_n) else $error("power without flag");
  AST_VCONN_SIDE: assert property (@(posedge pclk) disable iff (!presetn)
    drive.vconn_cc1 |-> !flip_orientation_n_flag_oe_n) else $error("vconn1 not flipped");
  AST_FLIP_NEEDS_ATTACH: assert property (@(posedge pclk) disable iff (!presetn)
    !flip_orientation_n_flag_oe_n |-> !sink_attached_n_flag_oe_n)
    else $error("flip flag alone");
  AST_FAULT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    fault_act |=> !fault_n_flag_oe_n && !drive.power_on) else $error("fault missed");
  AST_FAULT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fault_act) |=> fault_n_flag_oe_n) else $error("fault stuck");
  AST_ADV: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 drive.adv_15a == $past(sel_s)) else $error("advertisement wrong");
  AST_OUT_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
    !sink_attached_n_flag_o && !flip_orientation_n_flag_o && !fault_n_flag_o)
    else $error("flag level high");
  COV_ATTACH: cover property (@(posedge pclk) disable iff (!presetn) $rose(drive.power_on));
  COV_FLIP: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(flip_orientation_n_flag_oe_n));
  COV_VCONN2: cover property (@(posedge pclk) disable iff (!presetn) $rose(drive.vconn_cc2));
  COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) $fell(fault_n_flag_oe_n));
  COV_DETACH: cover property (@(posedge pclk) disable iff (!presetn) $fell(drive.power_on));

  // Attach sequencing
  AST_SOURCE_FAR_END: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cc_attach_pkg::ST_UNATTACHED && !rd_now_any |=>
    state_r == cc_attach_pkg::ST_UNATTACHED) else $error("left idle without Rd");
  AST_RD_ATTACHES: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cc_attach_pkg::ST_WAIT_ATTACH && state_nxt == cc_attach_pkg::ST_ATTACHED |=>
    !sink_attached_n_flag_oe_n) else $error("attach not flagged");
  AST_ATTACH_DEBOUNCED: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sink_attached_n_flag_oe_n) |-> rd_age_r >= DEB_MAX)
    else $error("attach before debounce");
  AST_NO_DIRECT_ATTACH: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cc_attach_pkg::ST_UNATTACHED |=> state_r != cc_attach_pkg::ST_ATTACHED)
    else $error("debounce skipped");
  AST_DETACH_PROMPT: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cc_attach_pkg::ST_ATTACHED && !rd_now_any |=>
    state_r == cc_attach_pkg::ST_UNATTACHED) else $error("slow detach");
  AST_DEB_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    cc_now != cc_last_r |=> deb_cnt_r == '0) else $error("debounce not restarted");

  // Orientation, VCONN side and fault flag while disabled
  AST_FLIP_CC2: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == cc_attach_pkg::ST_WAIT_ATTACH && state_nxt == cc_attach_pkg::ST_ATTACHED &&
    rd2_st && !rd1_st |=> !flip_orientation_n_flag_oe_n) else $error("flip missed");
  AST_VCONN2_SIDE: assert property (@(posedge pclk) disable iff (!presetn)
    drive.vconn_cc2 |-> !sink_attached_n_flag_oe_n && flip_orientation_n_flag_oe_n)
    else $error("vconn2 wrong side");
  AST_FAULT_HIDDEN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !port_en |=> fault_n_flag_oe_n) else $error("fault shown while off");

  // Register bus
  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready held");
  AST_SLVERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("pslverr alone");
  AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && paddr == `REG_CTRL_ADDR |=> ctrl_r[`CTRL_ENABLE_BIT] == $past(pwdata[0]))
    else $error("enable write lost");
  AST_UNMAPPED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("unmapped data");
endmodule

// *** src/cc_attach_params.svh ***
`ifndef CC_ATTACH_PARAMS_SVH
`define CC_ATTACH_PARAMS_SVH
// Overview of operation
// - Enable input low turns the port off; high resumes normal operation. Here high resumes it only while the CTRL enable bit is also set.
// - Static select input chooses standard or 1.5-A advertisement on CC lines.
// - No Rd on either line: output off, attach and polarity flags released.
// - Both CC lines are watched continuously for an Rd pull-down.
// - Facing another source, no Rd appears: output stays off, monitoring continues.
// - Rd on any one CC line means attached; input power goes to output.
// - Rd on one line, Ra on other: VCONN is driven onto the Ra line.
// - Ra with the other line open is no attach; everything stays inactive.
// - Attach flag pulled low whenever a sink is detected, released otherwise.
// - Polarity flag pulled low when Rd is on CC2, released otherwise.
// - Fault flag asserts on overcurrent or either overtemperature threshold.
// - Fault flag self-clears once current and temperature are back to normal.

// Register map
`define REG_CTRL_ADDR 12'h000
`define REG_STATUS_ADDR 12'h004
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VAL 32'h0000_0001
// Status fields
`define ST_ATTACHED_BIT 0
`define ST_FLIPPED_BIT 1
`define ST_POWER_BIT 2
`define ST_VCONN1_BIT 3
`define ST_VCONN2_BIT 4
`define ST_FAULT_BIT 5
`define ST_ADV15_BIT 6
`define ST_ENABLED_BIT 7
// Debounce: 100 us at 250 MHz
`define DEBOUNCE_US 100
`define CLK_MHZ 250
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define DEB_W 16
`endif

// *** src/cc_attach_pkg.sv ***
package cc_attach_pkg;
  // Termination seen on one CC line
  typedef enum logic [1:0] {
    TERM_OPEN = 2'b00,
    TERM_RA = 2'b01,
    TERM_RD = 2'b10
  } term_t;
  typedef enum logic [1:0] {
    ST_UNATTACHED = 2'b00,
    ST_WAIT_ATTACH = 2'b01,
    ST_ATTACHED = 2'b11
  } attach_state_t;
  typedef struct packed {
    term_t cc1;
    term_t cc2;
  } cc_pair_t;
  typedef struct packed {
    logic power_on;
    logic vconn_cc1;
    logic vconn_cc2;
    logic adv_15a;
  } port_drive_t;
endpackage

// *** dv/sink_cable_model.sv ***
`timescale 1ns/1ps
// Far end as seen by the CC comparators: 0 open, 1 cable only, 2 sink, 3 sink flipped
module sink_cable_model (
  input wire logic [1:0] mode,
  output logic cc1_rd_det,
  output logic cc1_ra_det,
  output logic cc2_rd_det,
  output logic cc2_ra_det
);
  always_comb begin
    case (mode)
      2'd1: {cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det} = 4'h4;
      2'd2: {cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det} = 4'h9;
      2'd3: {cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det} = 4'h6;
      default: {cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det} = 4'h0;
    endcase
  end
endmodule

// *** dv/typec_source_cc_attach_control_tb_top.sv ***
`timescale 1ns/1ps
module typec_source_cc_attach_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enable_pin = 1'b1;
  logic adv_sel = 1'b0;
  logic [2:0] fault_in = 3'h0;
  logic [1:0] mode = 2'd0;
  logic c1d, c1a, c2d, c2a;
  cc_attach_pkg::port_drive_t drive;
  logic att_o, att_oe_n, flip_o, flip_oe_n, flt_o, flt_oe_n;
  logic [31:0] q;
  logic e;
  int miscompares = 0;
  int total_checks = 0;
  always #2 pclk = ~pclk;
  sink_cable_model u_far (.mode(mode), .cc1_rd_det(c1d), .cc1_ra_det(c1a),
    .cc2_rd_det(c2d), .cc2_ra_det(c2a));
  typec_source_cc_attach_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .current_adv_select(adv_sel), .cc1_rd_det(c1d), .cc1_ra_det(c1a), .cc2_rd_det(c2d),
    .cc2_ra_det(c2a), .overcurrent(fault_in[0]), .overtemp_device(fault_in[1]),
    .overtemp_switch(fault_in[2]), .drive(drive), .sink_attached_n_flag_o(att_o),
    .sink_attached_n_flag_oe_n(att_oe_n), .flip_orientation_n_flag_o(flip_o),
    .flip_orientation_n_flag_oe_n(flip_oe_n), .fault_n_flag_o(flt_o),
    .fault_n_flag_oe_n(flt_oe_n));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Bounded wait on the slave answer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task automatic chk_reg(input logic [31:0] exp, input logic experr);
    total_checks++;
    if (q !== exp || e !== experr) begin
      miscompares++;
      $display("[ERR] %0t reg got %h/%b exp %h/%b", $time, q, e, exp, experr);
    end
  endtask
  // Pins packed as drive, attach oe_n, flip oe_n, fault oe_n
  task automatic chk_pins(input logic [6:0] exp, input logic [6:0] m);
    logic [6:0] got;
    got = {drive, att_oe_n, flip_oe_n, flt_oe_n};
    total_checks++;
    if (((got ^ exp) & m) !== 7'h00 || {att_o, flip_o, flt_o} !== 3'h0) begin
      miscompares++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk_pins(7'h07, 7'h7f);
    apb(1'b0, 12'h000, 32'h0);
    chk_reg(32'h0000_0001, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk_reg(32'h0000_0000, 1'b1);
    $display("test reset done");
    mode <= 2'd1;
    wt(25100);
    chk_pins(7'h07, 7'h7f);
    $display("test cable only done");
    mode <= 2'd2;
    wt(25010);
    chk_pins(7'h53, 7'h7f);
    for (int i = 0; i < 3; i++) begin
      fault_in <= 3'h1 << i;
      wt(5);
      chk_pins(7'h00, 7'h41);
      fault_in <= 3'h0;
      wt(5);
      chk_pins(7'h53, 7'h7f);
    end
    mode <= 2'd0;
    wt(5);
    chk_pins(7'h07, 7'h7f);
    $display("test sink attach done");
    adv_sel <= 1'b1;
    mode <= 2'd3;
    wt(20000);
    chk_pins(7'h00, 7'h40);
    wt(5010);
    chk_pins(7'h69, 7'h7f);
    apb(1'b0, 12'h004, 32'h0);
    chk_reg(32'h0000_00cf, 1'b0);
    enable_pin <= 1'b0;
    wt(5);
    chk_pins(7'h04, 7'h64);
    enable_pin <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk_reg(32'h0000_0000, 1'b0);
    $display("test flipped cable done");
    stop_test();
  end
endmodule
